// >>> rtl/csr_pkg.sv
// Purpose: Shared constants and types for the channel select register block.
// Assumes: 16-bit register data on an 8-bit register address port.
// ============================================================
package csr_pkg;

	// ============================================================
	// Register map
	localparam logic [7:0] CSR_CH0_ADDR = 8'h10;
	localparam logic [7:0] CSR_SETUP_BASE = 8'h20;
	localparam logic [7:0] CSR_SETUP_LAST = 8'h3F;
	localparam logic [15:0] CSR_CH0_RESET = 16'h8001;
	localparam logic [15:0] CSR_CH0_WMASK = 16'hF3FF;

	// ============================================================
	// Field positions
	localparam int CSR_EN_BIT = 15;
	localparam int CSR_SETUP_LSB = 12;
	localparam int CSR_POS_LSB = 5;
	localparam int CSR_NEG_LSB = 0;

	// ============================================================
	// Sizes
	localparam int CSR_NUM_CH = 16;
	localparam int CSR_NUM_SETUPS = 8;
	localparam int CSR_REGS_PER_SETUP = 4;
	localparam int CSR_MEM_DEPTH = 32;
	localparam logic [1:0] CSR_LAST_SETUP_REG = 2'h3;

	typedef enum logic [1:0]
	{
		CSR_SEQ_FETCH,
		CSR_SEQ_CAPTURE,
		CSR_SEQ_READY
	} csr_seq_t;

endpackage : csr_pkg

// >>> rtl/csr_mem_if.sv
// Purpose: Carries the setup memory ports between the control logic and the memory.
// Assumes: One clock, all signals synchronous to it.
// Notes: Two read ports so that bus reads never wait on the sequencer.
`timescale 1ns/10ps
`default_nettype none
interface csr_mem_if;
	logic [4:0] busAddr;
	logic busWrite;
	logic [15:0] busWrData;
	logic [15:0] busRdData;
	logic [4:0] seqAddr;
	logic [15:0] seqRdData;

	modport ctrl
	(
		output busAddr,
		output busWrite,
		output busWrData,
		output seqAddr,
		input busRdData,
		input seqRdData
	);

	modport mem
	(
		input busAddr,
		input busWrite,
		input busWrData,
		input seqAddr,
		output busRdData,
		output seqRdData
	);
endinterface : csr_mem_if
`default_nettype wire

// >>> rtl/csr_setup_mem.sv
// Purpose: Holds the eight setup groups of four 16-bit registers.
// Assumes: Word index is setup number times four plus register number.
// Notes: Both read ports are registered, so data arrive one cycle after the address.
`timescale 1ns/10ps
`default_nettype none
module csr_setup_mem
(
	input wire logic clk,
	csr_mem_if.mem port
);
	logic [15:0] store [csr_pkg::CSR_MEM_DEPTH];

	// ============================================================
	// Write and registered reads
	always_ff @(posedge clk)
	begin
		if (port.busWrite)
		begin
			store[port.busAddr] <= port.busWrData;
		end
		port.busRdData <= store[port.busAddr];
		port.seqRdData <= store[port.seqAddr];
	end
endmodule : csr_setup_mem
`default_nettype wire

// >>> rtl/csr_channel_select.sv
// Purpose: Channel 0 configuration register, setup store and channel sequencer.
// Assumes: Other channels' enables and setup codes come from outside on the same clock.
// Notes: A conversion on the active channel should start only while setupReady is high.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module csr_channel_select
(
	input wire logic clk,
	input wire logic srst,
	input wire logic [7:0] regAddr,
	input wire logic [15:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [15:0] regRdData,
	input wire logic [15:1] otherChannelEnable,
	input wire logic [2:0] otherSetupSelect,
	input wire logic conversionDone,
	output logic channel0_enable,
	output logic [2:0] channel0_setup_select,
	output logic [4:0] channel0_positive_input_select,
	output logic [4:0] channel0_negative_input_select,
	output logic [3:0] activeChannel,
	output logic [15:0] setupConfig,
	output logic [15:0] filterConfig,
	output logic [15:0] setupOffset,
	output logic [15:0] setupGain,
	output logic setupReady
);
	logic [15:0] channel0_config;
	logic [15:0] chRdData;
	logic memRdSel;
	logic [15:0] channelEnables;
	logic [2:0] activeSetup;
	logic [1:0] fetchIndex;
	logic [1:0] captureIndex;
	logic [3:0] next_channel;
	logic advance;
	logic busHitCh0;
	logic busHitSetup;
	csr_pkg::csr_seq_t seqState;
	csr_mem_if memPort ();

	// ============================================================
	// Helpers
	function automatic logic [3:0] csr_next_enabled
	(
		input logic [15:0] en,
		input logic [3:0] cur
	);
		logic [3:0] idx;
		logic [3:0] result;
		logic found;
		result = cur;
		found = 1'b0;
		for (int i = 1; i <= csr_pkg::CSR_NUM_CH; i++)
		begin
			idx = 4'(cur + 4'(i));
			if (en[idx] && !found)
			begin
				result = idx;
				found = 1'b1;
			end
		end
		return result;
	endfunction : csr_next_enabled

	function automatic logic [4:0] csr_setup_word
	(
		input logic [2:0] setup,
		input logic [1:0] index
	);
		return {setup, index};
	endfunction : csr_setup_word

	// ============================================================
	// Address decode
	assign busHitCh0 = (regAddr == csr_pkg::CSR_CH0_ADDR);
	assign busHitSetup = (regAddr >= csr_pkg::CSR_SETUP_BASE) && (regAddr <= csr_pkg::CSR_SETUP_LAST);

	// ============================================================
	// Channel 0 configuration register
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			channel0_config <= csr_pkg::CSR_CH0_RESET;
		end
		else if (regWrite && busHitCh0)
		begin
			// Reserved bits are never stored, so a careless write cannot set them.
			channel0_config <= regWrData & csr_pkg::CSR_CH0_WMASK;
		end
	end

	assign channel0_enable = channel0_config[csr_pkg::CSR_EN_BIT];
	assign channel0_setup_select = channel0_config[csr_pkg::CSR_SETUP_LSB +: 3];
	assign channel0_positive_input_select = channel0_config[csr_pkg::CSR_POS_LSB +: 5];
	assign channel0_negative_input_select = channel0_config[csr_pkg::CSR_NEG_LSB +: 5];

	// ============================================================
	// Register reads
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			chRdData <= 16'h0000;
			memRdSel <= 1'b0;
		end
		else if (regRead)
		begin
			chRdData <= busHitCh0 ? (channel0_config & csr_pkg::CSR_CH0_WMASK) : 16'h0000;
			memRdSel <= busHitSetup;
		end
		else
		begin
			chRdData <= 16'h0000;
			memRdSel <= 1'b0;
		end
	end

	// Both sources are flip-flops; the mux keeps bus reads free of any wait.
	assign regRdData = memRdSel ? memPort.busRdData : chRdData;

	// ============================================================
	// Setup store
	assign memPort.busAddr = regAddr[4:0];
	assign memPort.busWrite = regWrite && busHitSetup;
	assign memPort.busWrData = regWrData;
	assign memPort.seqAddr = csr_setup_word(activeSetup, fetchIndex);

	csr_setup_mem setupMem
	(
		.clk(clk),
		.port(memPort)
	);

	// ============================================================
	// Channel sequencer
	assign channelEnables = {otherChannelEnable, channel0_enable};
	assign activeSetup = (activeChannel == 4'h0) ? channel0_setup_select : otherSetupSelect;
	assign next_channel = csr_next_enabled(channelEnables, activeChannel);
	// A channel switched off while active is left at once, not after its conversion.
	assign advance = (seqState == csr_pkg::CSR_SEQ_READY) &&
		(conversionDone || !channelEnables[activeChannel]) && (next_channel != activeChannel);

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			activeChannel <= 4'h0;
		end
		else if (advance)
		begin
			activeChannel <= next_channel;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			seqState <= csr_pkg::CSR_SEQ_FETCH;
			fetchIndex <= 2'h0;
			captureIndex <= 2'h0;
		end
		else
		begin
			case (seqState)
				csr_pkg::CSR_SEQ_FETCH:
				begin
					fetchIndex <= 2'h1;
					captureIndex <= 2'h0;
					seqState <= csr_pkg::CSR_SEQ_CAPTURE;
				end
				csr_pkg::CSR_SEQ_CAPTURE:
				begin
					captureIndex <= fetchIndex - 2'h1;
					if (captureIndex == csr_pkg::CSR_LAST_SETUP_REG)
					begin
						fetchIndex <= 2'h0;
						seqState <= csr_pkg::CSR_SEQ_READY;
					end
					else
					begin
						fetchIndex <= fetchIndex + 2'h1;
						captureIndex <= captureIndex + 2'h1;
					end
				end
				csr_pkg::CSR_SEQ_READY:
				begin
					if (advance)
					begin
						fetchIndex <= 2'h0;
						seqState <= csr_pkg::CSR_SEQ_FETCH;
					end
				end
				default:
				begin
					fetchIndex <= 2'h0;
					seqState <= csr_pkg::CSR_SEQ_FETCH;
				end
			endcase
		end
	end

	// The group is copied whole, so software edits take effect at the next channel switch.
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			setupConfig <= 16'h0000;
			filterConfig <= 16'h0000;
			setupOffset <= 16'h0000;
			setupGain <= 16'h0000;
		end
		else if (seqState == csr_pkg::CSR_SEQ_CAPTURE)
		begin
			case (captureIndex)
				2'h0: setupConfig <= memPort.seqRdData;
				2'h1: filterConfig <= memPort.seqRdData;
				2'h2: setupOffset <= memPort.seqRdData;
				default: setupGain <= memPort.seqRdData;
			endcase
		end
	end

	assign setupReady = (seqState == csr_pkg::CSR_SEQ_READY);

endmodule : csr_channel_select
`default_nettype wire

// >>> test/csr_channel_select_properties.sv
// Purpose: Port checks for csr_channel_select.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound to every instance of the block.
`timescale 1ns/10ps
`default_nettype none
module csr_properties
(
	input wire logic clk,
	input wire logic srst,
	input wire logic [7:0] regAddr,
	input wire logic [15:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [15:0] regRdData,
	input wire logic [15:1] otherChannelEnable,
	input wire logic conversionDone,
	input wire logic channel0_enable,
	input wire logic [2:0] channel0_setup_select,
	input wire logic [4:0] channel0_positive_input_select,
	input wire logic [4:0] channel0_negative_input_select,
	input wire logic [3:0] activeChannel,
	input wire logic setupReady
);
	logic [15:0] fields;
	assign fields = {channel0_enable, channel0_setup_select, 2'h0, channel0_positive_input_select,
		channel0_negative_input_select};
	default clocking @(posedge clk);
	endclocking
	default disable iff (srst);
	// ============================================================
	// Checks
	// Checked on release, because the default disable masks every cycle that has reset high.
	reset_value_a: assert property ($fell(srst) |-> fields == 16'h8001 && activeChannel == 4'h0
		&& !setupReady && regRdData == 16'h0000)
		else $error("channel register reset value wrong");
	write_fields_a: assert property (regWrite && regAddr == 8'h10 |=> fields == ($past(regWrData) & 16'hF3FF))
		else $error("channel register write not stored");
	read_back_a: assert property (regRead && regAddr == 8'h10 |=> regRdData == $past(fields))
		else $error("channel register read wrong");
	hold_fields_a: assert property (!(regWrite && regAddr == 8'h10) |=> $stable(fields))
		else $error("channel register changed without write");
	unmapped_read_a: assert property (regRead && regAddr < 8'h10 |=> regRdData == 16'h0000)
		else $error("unmapped read not zero");
	seq_advance_a: assert property (setupReady && conversionDone && channel0_enable && otherChannelEnable != 15'h0000
		|=> !setupReady && activeChannel != $past(activeChannel))
		else $error("sequencer did not advance");
	setup_fetch_a: assert property ($fell(setupReady) |-> !setupReady [*5] ##1 setupReady)
		else $error("setup fetch time wrong");
	ascend_skip_a: assert property (setupReady && (conversionDone || !channel0_enable) && activeChannel == 4'h0
		&& otherChannelEnable[1] |=> activeChannel == 4'h1)
		else $error("sequencer order wrong");
	sole_channel_a: assert property (setupReady && conversionDone && !channel0_enable && otherChannelEnable == 15'h0001
		&& activeChannel == 4'h1 |=> setupReady && activeChannel == 4'h1)
		else $error("sole channel refetched");
endmodule : csr_properties
bind csr_channel_select csr_properties chk_props (.clk, .srst, .regAddr, .regWrData, .regWrite, .regRead,
	.regRdData, .otherChannelEnable, .conversionDone, .channel0_enable, .channel0_setup_select,
	.channel0_positive_input_select, .channel0_negative_input_select, .activeChannel, .setupReady);
`default_nettype wire

// >>> test/channel_select_register_test.sv
// Purpose: Self-checking bench for csr_channel_select.
// Assumes: Inputs change by non-blocking assignment at the rising edge.
// Notes: Setup words reach the outputs only after reset and at a channel switch, so memory is filled first.
`timescale 1ns/10ps
`default_nettype none
module channel_select_register_test;
	logic clk = 1'h0, srst = 1'h1, regWrite = 1'h0, regRead = 1'h0, conversionDone = 1'h0;
	logic [7:0] regAddr = 8'h00;
	logic [15:0] regWrData = 16'h0000, model = 16'h8001, v;
	logic [15:1] otherChannelEnable = 15'h0000;
	logic [2:0] otherSetupSelect = 3'h0, sel0;
	logic [15:0] regRdData, setupConfig, filterConfig, setupOffset, setupGain;
	logic [15:0] mem [32];
	logic en0, setupReady;
	logic [4:0] pos0, neg0;
	logic [3:0] activeChannel;
	int miscompares = 0, n_tests = 0, seed = 32'h0dc1_557b, i;
	csr_channel_select DUT (.clk, .srst, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
		.otherChannelEnable, .otherSetupSelect, .conversionDone, .channel0_enable(en0),
		.channel0_setup_select(sel0), .channel0_positive_input_select(pos0),
		.channel0_negative_input_select(neg0), .activeChannel, .setupConfig, .filterConfig,
		.setupOffset, .setupGain, .setupReady);
	initial
		forever #10 clk = ~clk;
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		regWrite <= 1'h1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk);
		regWrite <= 1'h0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk);
		regRead <= 1'h1;
		regAddr <= a;
		@(posedge clk);
		regRead <= 1'h0;
		#1 chk(regRdData, e);
	endtask : rd
	// Without a pulse the two edges give a disabled channel time to be left.
	task automatic step(input logic go, input logic [3:0] ch, input logic [2:0] s);
		int t;
		@(posedge clk);
		conversionDone <= go;
		@(posedge clk);
		conversionDone <= 1'h0;
		#1;
		for (t = 0; t < 20 && setupReady !== 1'h1; t++)
		begin
			@(posedge clk);
			#1;
		end
		if (t == 20)
		begin
			miscompares++;
			give_verdict();
		end
		else
		begin
			chk({12'h000, activeChannel}, {12'h000, ch});
			chk(setupConfig, mem[{s, 2'h0}]);
			chk(filterConfig, mem[{s, 2'h1}]);
			chk(setupOffset, mem[{s, 2'h2}]);
			chk(setupGain, mem[{s, 2'h3}]);
		end
	endtask : step
	// ============================================================
	// Main sequence
	initial
	begin
		repeat (4) @(posedge clk);
		srst <= 1'h0;
		rd(8'h10, 16'h8001);
		for (i = 0; i < 8; i++)
		begin
			v = 16'($random(seed));
			v[14:12] = i[2:0];
			v[9:5] = {2'h0, i[2:0]};
			model = v & 16'hF3FF;
			wr(8'h10, v);
			rd(8'h10, model);
			chk({en0, sel0, 2'h0, pos0, neg0}, model);
		end
		for (i = 0; i < 32; i++)
		begin
			mem[i] = 16'($random(seed));
			wr(8'h20 + 8'(i), mem[i]);
		end
		for (i = 0; i < 32; i++)
			rd(8'h20 + 8'(i), mem[i]);
		wr(8'h05, 16'hFFFF);
		rd(8'h05, 16'h0000);
		rd(8'h10, model);
		wr(8'h10, 16'hB0E1);
		otherChannelEnable <= 15'h0005;
		otherSetupSelect <= 3'h5;
		step(1'h1, 4'h1, 3'h5);
		step(1'h1, 4'h3, 3'h5);
		step(1'h1, 4'h0, 3'h3);
		wr(8'h10, 16'h30E1);
		step(1'h0, 4'h1, 3'h5);
		@(posedge clk);
		otherChannelEnable <= 15'h0001;
		step(1'h1, 4'h1, 3'h5);
		// Channel 0 now shares setup 5 with the other channels.
		wr(8'h10, 16'hD0E1);
		step(1'h1, 4'h0, 3'h5);
		give_verdict();
	end
endmodule : channel_select_register_test
`default_nettype wire
